// >>> acpm_top.sv
// Pair-mode, converter B clock and DMA trigger select logic.
`timescale 1ns/100ps
`default_nettype none
module acpm_top (
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    input  wire acpm_pkg::acpm_bus_req_s bus_req,
    output var  logic [15:0]            rdata,
    input  wire acpm_pkg::acpm_scan_e   scan_mode,
    input  wire logic [5:0]             primary_clock_divisor,
    input  wire logic [7:0]             pair_config_diff,
    input  wire logic                   end_of_scan_irq_a,
    input  wire logic                   end_of_scan_irq_b,
    input  wire logic                   ready_flags_event,
    output var  logic                   conv_a_clk_en,
    output var  logic                   conv_b_clk_en,
    output var  logic [7:0]             pair_unipolar,
    output var  logic [7:0]             pair_fully_diff,
    output var  logic                   dma_req_a,
    output var  logic                   dma_req_b
);
    import acpm_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    acpm_state_s st_q;
    acpm_state_s st_d;
    logic        nonsim;
    logic        tick_primary;
    logic        tick_second;
    logic [5:0]  second_divisor;

    // Only non-simultaneous parallel scans split the converter clocks.
    assign nonsim = (scan_mode == ACPM_SCAN_PAR_NONSIM);

    // ------------------------------------------------------------------
    // Conversion clock dividers
    // ------------------------------------------------------------------

    // Primary divider feeds converter A always, and B in shared modes.
    acpm_clk_div u_div_primary (
        .clock   (clock),
        .reset_n (reset_n),
        .divisor (primary_clock_divisor),
        .run     (1'b1),
        .tick    (tick_primary)
    );

    assign second_divisor = st_q.converter_b_clock_divisor;

    // second divider idles
    // Holding it stopped outside the split mode keeps its phase fresh for
    // the next non-simultaneous scan instead of a stale half period.
    acpm_clk_div u_div_second (
        .clock   (clock),
        .reset_n (reset_n),
        .divisor (second_divisor),
        .run     (nonsim),
        .tick    (tick_second)
    );

    assign conv_a_clk_en = tick_primary;
    assign conv_b_clk_en = nonsim ? tick_second : tick_primary;

    // ------------------------------------------------------------------
    // Register port, pair style and DMA trigger steering
    // ------------------------------------------------------------------

    // Next-state logic for registers, read data and steered outputs.
    always_comb begin
        st_d = st_q;
        st_d.rdata = '0;

        // Register writes; reserved bits are simply not stored.
        if (bus_req.write) begin
            unique case (bus_req.addr)
                ACPM_OFF_PWR_TWO: begin
                    st_d.converter_b_clock_divisor =
                        bus_req.wdata[ACPM_DIV_LSB +: ACPM_DIV_W];
                end
                ACPM_OFF_CTRL_THREE: begin
                    st_d.pair_select[7:4] =
                        bus_req.wdata[ACPM_PAIR_LSB + 4 +: 4];
                    st_d.pair_select[3:0] =
                        bus_req.wdata[ACPM_PAIR_LSB +: 4];
                    st_d.dma_trigger_select =
                        bus_req.wdata[ACPM_DMA_SEL_BIT];
                end
                default: begin
                end
            endcase
        end

        // Register reads; unmapped addresses and reserved bits give zero.
        if (bus_req.read) begin
            unique case (bus_req.addr)
                ACPM_OFF_PWR_TWO: begin
                    st_d.rdata[ACPM_DIV_LSB +: ACPM_DIV_W] =
                        st_q.converter_b_clock_divisor;
                end
                ACPM_OFF_CTRL_THREE: begin
                    st_d.rdata[ACPM_PAIR_LSB +: ACPM_PAIRS] =
                        st_q.pair_select;
                    st_d.rdata[ACPM_DMA_SEL_BIT] = st_q.dma_trigger_select;
                end
                default: begin
                end
            endcase
        end

        st_d.pair_unipolar   = pair_config_diff & st_q.pair_select;
        st_d.pair_fully_diff = pair_config_diff & ~st_q.pair_select;

        // Request lines are registered so the DMA sees glitch-free levels;
        // the cost is one cycle of latency after the source event.
        st_d.dma_req_a = 1'b0;
        st_d.dma_req_b = 1'b0;
        unique case (scan_mode)
            ACPM_SCAN_SEQ, ACPM_SCAN_PAR_SIM: begin
                st_d.dma_req_a = st_q.dma_trigger_select ?
                                 ready_flags_event : end_of_scan_irq_a;
            end
            ACPM_SCAN_PAR_NONSIM: begin
                if (st_q.dma_trigger_select) begin
                    st_d.dma_req_a = ready_flags_event;
                end else begin
                    st_d.dma_req_a = end_of_scan_irq_a;
                    st_d.dma_req_b = end_of_scan_irq_b;
                end
            end
            default: begin
                // An undefined mode code raises no request at all.
            end
        endcase
    end

    // State register; every control bit has a defined reset value.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.converter_b_clock_divisor <= ACPM_RST_DIV;
            st_q.pair_select               <= ACPM_RST_PAIR_SEL;
            st_q.dma_trigger_select        <= ACPM_RST_DMA_SEL;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // All data outputs come straight from the state register.
    assign rdata           = st_q.rdata;
    assign pair_unipolar   = st_q.pair_unipolar;
    assign pair_fully_diff = st_q.pair_fully_diff;
    assign dma_req_a       = st_q.dma_req_a;
    assign dma_req_b       = st_q.dma_req_b;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    a_rsvd_pwr_read: assert property (@(posedge clock)
        disable iff (!reset_n)
        (bus_req.read && bus_req.addr == ACPM_OFF_PWR_TWO)
            |=> (rdata[15:14] == 2'b00 && rdata[7:0] == 8'h00))
        else $error("reserved power register bits read nonzero");

    a_rsvd_ctrl_read: assert property (@(posedge clock)
        disable iff (!reset_n)
        (bus_req.read && bus_req.addr == ACPM_OFF_CTRL_THREE)
            |=> (rdata[7] == 1'b0 && rdata[5:0] == 6'h00))
        else $error("reserved control register bits read nonzero");

    a_div_write_read: assert property (@(posedge clock)
        disable iff (!reset_n)
        (bus_req.write && bus_req.addr == ACPM_OFF_PWR_TWO)
            ##1 (bus_req.read && bus_req.addr == ACPM_OFF_PWR_TWO
                 && !bus_req.write)
            |=> (rdata[13:8] == $past(bus_req.wdata[13:8], 2)))
        else $error("converter B divisor not read back as written");

    a_pair_write_read: assert property (@(posedge clock)
        disable iff (!reset_n)
        (bus_req.write && bus_req.addr == ACPM_OFF_CTRL_THREE)
            ##1 (bus_req.read && bus_req.addr == ACPM_OFF_CTRL_THREE
                 && !bus_req.write)
            |=> (rdata[15:8] == $past(bus_req.wdata[15:8], 2)
                 && rdata[6] == $past(bus_req.wdata[6], 2)))
        else $error("control three fields not read back as written");

    a_style_exclusive: assert property (@(posedge clock)
        disable iff (!reset_n)
        (pair_unipolar & pair_fully_diff) == 8'h00)
        else $error("a pair shows both differential styles");

    a_single_ended: assert property (@(posedge clock)
        disable iff (!reset_n)
        ##1 ((pair_unipolar | pair_fully_diff)
             == $past(pair_config_diff)))
        else $error("style outputs do not follow differential pairs");

    a_lower_pair_effect: assert property (@(posedge clock)
        disable iff (!reset_n)
        (bus_req.write && bus_req.addr == ACPM_OFF_CTRL_THREE
         && bus_req.wdata[8] && pair_config_diff[0])
            ##1 pair_config_diff[0]
            |=> pair_unipolar[0])
        else $error("pair A0/A1 did not turn unipolar after write");

    a_dma_ready_src: assert property (@(posedge clock)
        disable iff (!reset_n)
        (st_q.dma_trigger_select && ready_flags_event
         && scan_mode != 2'b11)
            |=> dma_req_a)
        else $error("ready flags did not raise the DMA request");

    a_dma_single: assert property (@(posedge clock)
        disable iff (!reset_n)
        (scan_mode == ACPM_SCAN_SEQ || scan_mode == ACPM_SCAN_PAR_SIM)
            |=> (!dma_req_b && dma_req_a ==
                 ($past(st_q.dma_trigger_select) ?
                  $past(ready_flags_event) : $past(end_of_scan_irq_a))))
        else $error("shared-mode DMA trigger has wrong source");

    a_dma_split: assert property (@(posedge clock)
        disable iff (!reset_n)
        (nonsim && !st_q.dma_trigger_select)
            |=> (dma_req_a == $past(end_of_scan_irq_a)
                 && dma_req_b == $past(end_of_scan_irq_b)))
        else $error("split-mode DMA triggers do not follow end of scan");

    // B follows primary outside split mode
    a_b_clk_shared: assert property (@(posedge clock)
        disable iff (!reset_n)
        !nonsim |-> (conv_b_clk_en == conv_a_clk_en && !tick_second))
        else $error("converter B clock not from primary divider");

    // B clock from second divider in split mode
    a_b_clk_split: assert property (@(posedge clock)
        disable iff (!reset_n)
        nonsim |-> (conv_b_clk_en == tick_second))
        else $error("converter B clock not from second divider");

endmodule : acpm_top
`default_nettype wire

// >>> acpm_pkg.sv
// Constants, types and bundles shared by the converter pair-mode block.
//
// Behaviour
// - Reserved bits of both registers read as zero and ignore writes.
// - Power bits 13..8 set converter B clock in non-simultaneous scans.
// - Second divider divides exactly like the primary for equal values.
// - Control three bits 15..12 select style of pairs A4/5, A6/7, B4/5, B6/7.
// - Control three bits 11..8 select style of pairs A0/1, A2/3, B0/1, B2/3.
// - Style bit one means unipolar, zero means fully differential.
// - Style bit acts only on differential pairs; single-ended ignore it.
// - Control three bit 6 picks DMA source: zero end of scan, one ready.
// - Sequential and simultaneous: one trigger from end of scan A or ready.
// - Non-simultaneous: zero gives separate A and B end-of-scan triggers.
package acpm_pkg;

    // ------------------------------------------------------------------
    // Register map and field layout
    // ------------------------------------------------------------------
    localparam int          ACPM_ADDR_W        = 8;
    localparam int          ACPM_DATA_W        = 16;
    localparam logic [7:0]  ACPM_OFF_PWR_TWO   = 8'h53;
    localparam logic [7:0]  ACPM_OFF_CTRL_THREE = 8'h54;
    localparam int          ACPM_DIV_W         = 6;
    localparam int          ACPM_DIV_LSB       = 8;
    localparam int          ACPM_PAIRS         = 8;
    localparam int          ACPM_PAIR_LSB      = 8;
    localparam int          ACPM_DMA_SEL_BIT   = 6;
    localparam int          ACPM_CNT_W         = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [5:0]  ACPM_RST_DIV       = 6'h00;
    localparam logic [7:0]  ACPM_RST_PAIR_SEL  = 8'h00;
    localparam logic        ACPM_RST_DMA_SEL   = 1'b0;

    // Scan mode class reported by the scan sequencer.
    typedef enum logic [1:0] {
        ACPM_SCAN_SEQ        = 2'b00,
        ACPM_SCAN_PAR_SIM    = 2'b01,
        ACPM_SCAN_PAR_NONSIM = 2'b10
    } acpm_scan_e;

    // Register port request from software.
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        write;
        logic        read;
    } acpm_bus_req_s;

    // State of one conversion clock divider.
    typedef struct packed {
        logic [6:0] cnt;
        logic       tick;
    } acpm_div_state_s;

    // State of the register and steering logic.
    typedef struct packed {
        logic [5:0]  converter_b_clock_divisor;
        logic [7:0]  pair_select;
        logic        dma_trigger_select;
        logic [15:0] rdata;
        logic [7:0]  pair_unipolar;
        logic [7:0]  pair_fully_diff;
        logic        dma_req_a;
        logic        dma_req_b;
    } acpm_state_s;

endpackage : acpm_pkg

// >>> acpm_clk_div.sv
// Conversion clock divider producing a one-cycle enable pulse.
`timescale 1ns/100ps
`default_nettype none
module acpm_clk_div (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic [5:0] divisor,
    input  wire logic       run,
    output var  logic       tick
);
    import acpm_pkg::*;

    acpm_div_state_s st_q;
    acpm_div_state_s st_d;
    logic [6:0]      limit;

    // Period is 2*(divisor+1) cycles; the same rule serves both dividers.
    assign limit = {divisor, 1'b1};

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (!run) begin
            st_d.cnt = '0;
        end else if (st_q.cnt >= limit) begin
            st_d.cnt  = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 7'h01;
        end
    end

    // State register.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Gating by run drops a pulse launched in the last cycle before a stop,
    // so a stopped divider never leaks an enable into the next mode.
    assign tick = st_q.tick & run;

    // Helper: cycles since last pulse while divisor and run stay put.
    logic [7:0] gap_q;
    logic       seen_q;
    logic [5:0] div_q;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            gap_q  <= 8'h00;
            seen_q <= 1'b0;
            div_q  <= 6'h00;
        end else begin
            div_q  <= divisor;
            gap_q  <= st_q.tick ? 8'h00 : gap_q + 8'h01;
            if (!run || divisor != div_q) begin
                seen_q <= 1'b0;
            end else if (st_q.tick) begin
                seen_q <= 1'b1;
            end
        end
    end

    a_div_period: assert property (@(posedge clock) disable iff (!reset_n)
        (st_q.tick && seen_q && run && divisor == div_q)
            |-> (gap_q == {1'b0, limit}))
        else $error("divider pulse spacing differs from 2*(divisor+1)");

endmodule : acpm_clk_div
`default_nettype wire

// >>> tb_adc_pair_mode_dma_select.sv
// Self-checking testbench for the converter pair-mode and DMA select block.
`timescale 1ns/100ps
`default_nettype none
module tb_adc_pair_mode_dma_select;
    import acpm_pkg::*;

    // ----------------------------------------------------------------
    // Signals, clock and design instance
    // ----------------------------------------------------------------
    logic          clock;
    logic          reset_n;
    acpm_bus_req_s bus_req;
    logic [15:0]   rdata;
    acpm_scan_e    scan_mode;
    logic [5:0]    primary_clock_divisor;
    logic [7:0]    pair_config_diff;
    logic          end_of_scan_irq_a;
    logic          end_of_scan_irq_b;
    logic          ready_flags_event;
    logic          conv_a_clk_en;
    logic          conv_b_clk_en;
    logic [7:0]    pair_unipolar;
    logic [7:0]    pair_fully_diff;
    logic          dma_req_a;
    logic          dma_req_b;
    int            err_total;
    int            cmp_count;
    logic [15:0]   pwr_m;   // Mirror of the power register.
    logic [15:0]   ctl_m;   // Mirror of control register three.
    realtime       wr_end;  // Time at which the last write strobe ended.

    acpm_top acpm_top_i (
        .clock(clock), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
        .scan_mode(scan_mode), .primary_clock_divisor(primary_clock_divisor),
        .pair_config_diff(pair_config_diff),
        .end_of_scan_irq_a(end_of_scan_irq_a),
        .end_of_scan_irq_b(end_of_scan_irq_b),
        .ready_flags_event(ready_flags_event),
        .conv_a_clk_en(conv_a_clk_en), .conv_b_clk_en(conv_b_clk_en),
        .pair_unipolar(pair_unipolar), .pair_fully_diff(pair_fully_diff),
        .dma_req_a(dma_req_a), .dma_req_b(dma_req_b)
    );

    // Free-running 25 MHz clock.
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // Compare, bus and expectation helpers
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_int(input string what, input int exp, input int got);
        cmp_count++;
        if (got != exp) begin
            err_total++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_int

    // only writable fields are kept in the mirrors.
    task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.write <= 1'b1;
        @(posedge clock);
        bus_req.write <= 1'b0;
        wr_end = $realtime;
        if (a == ACPM_OFF_PWR_TWO) pwr_m = d & 16'h3f00;
        if (a == ACPM_OFF_CTRL_THREE) ctl_m = d & 16'hff40;
    endtask : bus_write

    // Read data is checked in the cycle after the strobe, then again one cycle later for zero.
    task automatic check_reg(input logic [7:0] a);
        logic [15:0] exp;
        exp = 16'h0000;
        if (a == ACPM_OFF_PWR_TWO) exp = pwr_m;
        if (a == ACPM_OFF_CTRL_THREE) exp = ctl_m;
        // A read straight after a write goes out with no gap between strobes.
        if (wr_end != $realtime) begin
            @(posedge clock);
        end
        bus_req.addr <= a;
        bus_req.read <= 1'b1;
        @(posedge clock);
        bus_req.read <= 1'b0;
        @(negedge clock);
        chk("register read", exp, rdata); // register fields
        @(negedge clock);
        chk("read data idle", 16'h0000, rdata); // read data returns zero
    endtask : check_reg

    // Waits three enable pulses so a half-finished interval is skipped.
    task automatic period_of(input logic sel_b, output int n);
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(negedge clock);
                n++;
            end while ((sel_b ? conv_b_clk_en : conv_a_clk_en) !== 1'b1
                       && n < 300);
            if (n >= 300) begin
                err_total++;
                $display("[FAIL] clock enable expected pulse seen none");
                print_verdict();
            end
        end
    endtask : period_of

    // expected requests as {b, a}; ev is {ready, eos b, eos a}.
    function automatic logic [1:0] exp_dma(input int m, input logic s,
                                           input logic [2:0] ev);
        if (m == 3) return 2'b00;
        if (s) return {1'b0, ev[2]};
        if (m == 2) return ev[1:0];
        return {1'b0, ev[0]};
    endfunction : exp_dma

    // Main sequence: registers, pair styles, DMA steering, dividers.
    initial begin : main
        logic [7:0] a;
        logic [2:0] ev;
        int         n;
        int         dv;
        void'($urandom(78812));
        err_total = 0;
        cmp_count = 0;
        pwr_m = 16'h0000;
        ctl_m = 16'h0000;
        reset_n = 1'b0;
        bus_req = '0;
        scan_mode = ACPM_SCAN_SEQ;
        primary_clock_divisor = 6'h00;
        pair_config_diff = 8'h00;
        {ready_flags_event, end_of_scan_irq_b, end_of_scan_irq_a} = 3'h0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        // All ones shows that reserved bits never stick.
        check_reg(ACPM_OFF_PWR_TWO);
        check_reg(ACPM_OFF_CTRL_THREE);
        bus_write(ACPM_OFF_PWR_TWO, 16'hffff);
        bus_write(ACPM_OFF_CTRL_THREE, 16'hffff);
        check_reg(ACPM_OFF_PWR_TWO);
        check_reg(ACPM_OFF_CTRL_THREE);
        // Random writes, unmapped ones among them, with pair styles.
        for (int i = 0; i < 24; i++) begin
            case ($urandom % 3)
                0: a = ACPM_OFF_PWR_TWO;
                1: a = ACPM_OFF_CTRL_THREE;
                default: a = 8'($urandom);
            endcase
            pair_config_diff <= 8'($urandom);
            bus_write(a, 16'($urandom));
            check_reg(a);
            chk("unipolar", {8'h00, ctl_m[15:8] & pair_config_diff},
                {8'h00, pair_unipolar}); // unipolar pairs
            chk("fully diff", {8'h00, ~ctl_m[15:8] & pair_config_diff},
                {8'h00, pair_fully_diff}); // fully differential
        end
        check_reg(ACPM_OFF_PWR_TWO);
        check_reg(ACPM_OFF_CTRL_THREE);
        // Every mode, both sources, every event combination.
        for (int m = 0; m < 4; m++) begin
            scan_mode <= acpm_scan_e'(m);
            for (int s = 0; s < 2; s++) begin
                bus_write(ACPM_OFF_CTRL_THREE,
                          {8'($urandom), 1'b1, s[0], 6'h3f});
                for (int e = 0; e < 8; e++) begin
                    @(posedge clock);
                    ev = 3'(e);
                    {ready_flags_event, end_of_scan_irq_b,
                     end_of_scan_irq_a} <= ev;
                    @(posedge clock);
                    @(negedge clock);
                    chk("dma", {14'h0000, exp_dma(m, s[0], ev)},
                        {14'h0000, dma_req_b, dma_req_a}); // dma
                end
            end
        end
        // Divider periods at the field limits and at random values.
        for (int i = 0; i < 4; i++) begin
            dv = (i == 0) ? 0 : (i == 1) ? 63 : int'($urandom % 64);
            scan_mode <= ACPM_SCAN_SEQ;
            primary_clock_divisor <= 6'(dv);
            bus_write(ACPM_OFF_PWR_TWO, 16'($urandom));
            period_of(1'b0, n);
            chk_int("primary period", 2 * (dv + 1), n); // divide rule
            repeat (40) begin
                @(negedge clock);
                chk("b follows a", {15'h0000, conv_a_clk_en},
                    {15'h0000, conv_b_clk_en}); // primary clock used
            end
            scan_mode <= ACPM_SCAN_PAR_NONSIM;
            bus_write(ACPM_OFF_PWR_TWO, {2'b11, 6'(63 - dv), 8'hff});
            period_of(1'b1, n);
            chk_int("second period", 2 * (64 - dv), n); // second divisor
            bus_write(ACPM_OFF_PWR_TWO, {2'b00, 6'(dv), 8'h00});
            period_of(1'b1, n);
            chk_int("equal period", 2 * (dv + 1), n); // equal divisors
        end
        print_verdict();
    end

endmodule : tb_adc_pair_mode_dma_select
`default_nettype wire
